//--- rtl/fcc_ahb_slave.sv
`timescale 1ns/1ps
module fcc_ahb_slave (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             rd_stb,
  output logic [7:0]       rd_addr,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  input  wire logic [31:0] rd_data
);

  logic        acc;
  logic        wp_q;
  logic        wp_d;
  logic        stall_q;
  logic        stall_d;
  logic [7:0]  waddr_q;
  logic [7:0]  waddr_d;
  logic [7:0]  raddr_q;
  logic [7:0]  raddr_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;

  // Only whole-word transfers are accepted; other sizes are ignored.
  assign acc       = hsel & htrans[1] & hready & (hsize == 3'h2);
  assign hreadyout = ~stall_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign wr_stb    = wp_q;
  assign wr_addr   = waddr_q;
  assign wr_data   = hwdata;

  // A read right behind a write waits one cycle so it sees the new value.
  always_comb begin
    wp_d     = acc & hwrite;
    waddr_d  = (acc & hwrite) ? haddr[7:0] : waddr_q;
    stall_d  = acc & ~hwrite & wp_q;
    raddr_d  = acc ? haddr[7:0] : raddr_q;
    rd_stb   = (acc & ~hwrite & ~wp_q) | stall_q;
    rd_addr  = stall_q ? raddr_q : haddr[7:0];
    hrdata_d = rd_stb ? rd_data : hrdata_q;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wp_q     <= 1'b0;
      stall_q  <= 1'b0;
      waddr_q  <= 8'h00;
      raddr_q  <= 8'h00;
      hrdata_q <= 32'h00000000;
    end else begin
      wp_q     <= wp_d;
      stall_q  <= stall_d;
      waddr_q  <= waddr_d;
      raddr_q  <= raddr_d;
      hrdata_q <= hrdata_d;
    end
  end

endmodule

//--- rtl/fcc_flash_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - Lower 62K usable; upper 2K firmware hidden.
// R2 - Boot select low at reset enables download.
// R3 - Bit 31 gates JTAG and parallel readout; the code drives only jtag_read_allow from it.
// R4 - Other 31 bits write-protect 2K groups.
// R5 - Immediate protection written directly, no key.
// R6 - Key guards keyed protection; mass erase resets.
// R7 - Software sequence: read, verify, key, command.
// R8 - Status bit 5 shows burst command.
// R9 - Status bit 3 interrupt flag, read clears.
// R10 - Status bit 2 busy while executing.
// R11 - Status bit 1 fail, read clears.
// R12 - Status bit 0 complete, read clears.
// R13 - Mode bit 4 enables completion interrupt.
// R14 - Code 01 reads word; 00 idles.
// R15 - Code 02 programs word, 20 us.
// R16 - Code 03 erases page, programs, 20 ms.
// R17 - Code 04 compares, result in fail bit.
// R18 - Code 05 erases addressed page.
// R19 - Keyed protection applies after reset; immediate now.
// R20 - Status register read-only, shows controller state.
// R21 - Command reads 07 after single commands.
// R22 - Code 06 mass erase, armed, 2.48 s.
// R23 - Protect accepted once; key or mass erase.
// R24 - Cleared protection bit protects; set allows.
// R25 - Command write starts; ignored while busy.
// R26 - Protected page program or erase fails.
module fcc_flash_ctrl
  import fcc_pkg::*;
#(
  parameter int EW_CYCLES_P   = fcc_pkg::EW_CYCLES,
  parameter int MASS_CYCLES_P = fcc_pkg::MASS_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        por_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        boot_select_pin,
  output logic             download_mode,
  output logic             jtag_read_allow,
  output logic             flash_irq,
  output logic             flash_rd_en,
  output logic             flash_prog_en,
  output logic             flash_page_erase_en,
  output logic             flash_mass_erase_en,
  output logic [15:0]      flash_addr,
  output logic [15:0]      flash_wdata,
  input  wire logic [15:0] flash_rdata
);
  import fcc_pkg::*;

  fcc_state_e      state_q, state_d;
  logic [7:0]      op_q, op_d, cmd_q, cmd_d, mode_q, mode_d;
  logic [15:0]     data_q, data_d, addr_q, addr_d;
  logic [31:0]     imm_q, imm_d, stage_q, stage_d, act_q, act_d;
  logic [31:0]     key_q, key_d, saved_q, saved_d;
  logic            keyset_q, keyset_d;
  logic            done_q, done_d, fail_q, fail_d, irq_q, irq_d;
  logic [1:0]      seq_q, seq_d, start_q, start_d;
  logic            dl_q, dl_d, boot_s1_q, boot_s2_q;
  logic            fl_rd_q, fl_rd_d, fl_prog_q, fl_prog_d;
  logic            fl_erase_q, fl_erase_d, fl_mass_q, fl_mass_d;
  logic            rd_stb, wr_stb, clr, fin, fin_fail, tmr_load, tmr_done;
  logic [7:0]      rd_addr, wr_addr, fin_op;
  logic [31:0]     wr_data, rd_data, eff;
  logic [TMR_W-1:0] tmr_val;
  logic            user, wp, wr_ok, key_ok, burst, busy;

  fcc_ahb_slave u_bus (
    .clock     (clock),
    .arst_n    (arst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_stb    (rd_stb),
    .rd_addr   (rd_addr),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_data   (rd_data)
  );

  fcc_timer #(.W(TMR_W)) u_tmr (
    .clock    (clock),
    .arst_n   (arst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  assign eff    = act_q & imm_q; // R19 R24
  assign user   = addr_q < USER_TOP; // R1
  assign wp     = ~eff[addr_q[GRP_MSB:GRP_LSB]] & ~dl_q; // R4 R2
  assign wr_ok  = user & ~wp; // R26
  assign key_ok = (seq_q == SEQ_VERIFY) && (mode_q[MODE_KEY_MSB:MODE_KEY_LSB] == KEY_ENABLE)
                  && (!keyset_q || ({addr_q, data_q} == key_q)); // R6 R7 R23
  assign burst  = (cmd_q == CMD_BURST_READ) || (cmd_q == CMD_BURST_RW)
                  || (cmd_q == CMD_BURST_ERW); // R8
  assign busy   = state_q != FCC_IDLE; // R10
  assign clr    = rd_stb && (rd_addr == OFS_STATUS); // R9 R11 R12
  assign fin_op = (state_q == FCC_IDLE) ? wr_data[7:0] : op_q;

  assign download_mode       = dl_q;
  assign jtag_read_allow     = eff[READ_PROT_BIT]; // R3
  assign flash_irq           = irq_q; // R13
  assign flash_rd_en         = fl_rd_q;
  assign flash_prog_en       = fl_prog_q;
  assign flash_page_erase_en = fl_erase_q;
  assign flash_mass_erase_en = fl_mass_q;
  assign flash_addr          = addr_q;
  assign flash_wdata         = data_q;

  // The status word has no write path at all.
  always_comb begin
    rd_data = 32'h00000000;
    case (rd_addr)
      OFS_STATUS: begin // R20
        rd_data[ST_DONE_BIT]  = done_q;
        rd_data[ST_FAIL_BIT]  = fail_q;
        rd_data[ST_BUSY_BIT]  = busy;
        rd_data[ST_IRQ_BIT]   = irq_q;
        rd_data[ST_BURST_BIT] = burst;
      end
      OFS_MODE:  rd_data[7:0] = mode_q;
      OFS_CMD:   rd_data[7:0] = cmd_q;
      OFS_DATA:  rd_data[15:0] = data_q;
      OFS_ADDR:  rd_data[15:0] = addr_q;
      OFS_KEYED: rd_data = stage_q;
      OFS_IMM:   rd_data = imm_q;
      OFS_INFO:  rd_data[1:0] = {keyset_q, dl_q};
      default:   rd_data = 32'h00000000;
    endcase
  end

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    cmd_d = cmd_q;
    mode_d = mode_q;
    data_d = data_q;
    addr_d = addr_q;
    imm_d = imm_q;
    stage_d = stage_q;
    act_d = act_q;
    seq_d = seq_q;
    start_d = start_q;
    dl_d = dl_q;
    key_d = key_q;
    keyset_d = keyset_q;
    saved_d = saved_q;
    fl_rd_d = 1'b0;
    fl_prog_d = 1'b0;
    fl_erase_d = 1'b0;
    fl_mass_d = 1'b0;
    tmr_load = 1'b0;
    tmr_val = '0;
    fin = 1'b0;
    fin_fail = 1'b0;
    // Keyed protection and the boot strap are sampled only after reset.
    if (start_q != START_CYCLES) begin
      start_d = start_q + 2'h1;
      act_d = saved_q; // R19
      dl_d = ~boot_s2_q; // R2
    end
    if (wr_stb) begin
      case (wr_addr)
        OFS_MODE:  mode_d = wr_data[7:0];
        OFS_DATA:  if (!busy) data_d = wr_data[15:0];
        OFS_ADDR:  if (!busy) addr_d = wr_data[15:0];
        OFS_KEYED: stage_d = wr_data;
        OFS_IMM:   imm_d = wr_data; // R5
        OFS_CMD: begin
          if (!busy) begin // R25
            cmd_d = wr_data[7:0];
            op_d = wr_data[7:0];
            seq_d = ((wr_data[7:0] == CMD_VERIFY) && (seq_q == SEQ_READ)) ? seq_q : SEQ_NONE;
            case (wr_data[7:0])
              CMD_READ, CMD_VERIFY: begin
                if (!user) begin // R1
                  fin = 1'b1;
                  fin_fail = 1'b1;
                end else begin
                  state_d = FCC_READ; // R14 R17
                  fl_rd_d = 1'b1;
                end
              end
              CMD_WRITE: begin
                if (!wr_ok) begin // R26
                  fin = 1'b1;
                  fin_fail = 1'b1;
                end else begin
                  state_d = FCC_PROG; // R15
                  fl_prog_d = 1'b1;
                  tmr_load = 1'b1;
                  tmr_val = TMR_W'(PROG_CYCLES);
                end
              end
              CMD_ERASE_WRITE, CMD_PAGE_ERASE: begin
                if (!wr_ok) begin // R26
                  fin = 1'b1;
                  fin_fail = 1'b1;
                end else begin
                  state_d = FCC_ERASE; // R16 R18
                  fl_erase_d = 1'b1;
                  tmr_load = 1'b1;
                  tmr_val = TMR_W'(EW_CYCLES_P - PROG_CYCLES);
                end
              end
              CMD_MASS: begin
                if ((seq_q == SEQ_VERIFY) && (data_q == MASS_ENABLE)) begin
                  state_d = FCC_MASS; // R22
                  fl_mass_d = 1'b1;
                  tmr_load = 1'b1;
                  tmr_val = TMR_W'(MASS_CYCLES_P);
                end else begin
                  fin = 1'b1;
                  fin_fail = 1'b1;
                end
              end
              CMD_PROTECT: begin
                fin = 1'b1;
                fin_fail = ~key_ok; // R23
                if (key_ok) begin
                  saved_d = stage_q; // R6
                  key_d = {addr_q, data_q};
                  keyset_d = 1'b1;
                end
              end
              CMD_NULL, CMD_BURST_READ: ; // R14
              default: begin
                fin = 1'b1;
                fin_fail = 1'b1;
              end
            endcase
          end
        end
        default: ;
      endcase
    end
    case (state_q)
      FCC_IDLE: ;
      FCC_READ: begin
        fin = 1'b1;
        state_d = FCC_IDLE;
        if (op_q == CMD_READ) begin
          data_d = flash_rdata; // R14
          seq_d = SEQ_READ;
        end else begin
          fin_fail = flash_rdata != data_q; // R17
          seq_d = (seq_q == SEQ_READ) ? SEQ_VERIFY : SEQ_NONE;
        end
      end
      FCC_ERASE: begin
        if (tmr_done) begin
          if (op_q == CMD_ERASE_WRITE) begin
            state_d = FCC_PROG; // R16
            fl_prog_d = 1'b1;
            tmr_load = 1'b1;
            tmr_val = TMR_W'(PROG_CYCLES);
          end else begin
            fin = 1'b1;
            state_d = FCC_IDLE;
          end
        end
      end
      FCC_PROG: begin
        if (tmr_done) begin
          fin = 1'b1;
          state_d = FCC_IDLE;
        end
      end
      FCC_MASS: begin
        if (tmr_done) begin
          fin = 1'b1;
          state_d = FCC_IDLE;
          key_d = KEY_ERASED; // R6
          keyset_d = 1'b0;
          saved_d = PROT_OPEN;
        end
      end
      default: state_d = FCC_IDLE;
    endcase
    if (fin && (fin_op >= CMD_READ) && (fin_op <= CMD_MASS)) begin
      cmd_d = CMD_BURST_READ; // R21
    end
  end

  // A completion in the same cycle as a status read survives the clear.
  assign done_d = (done_q & ~clr) | fin; // R12
  assign fail_d = (fail_q & ~clr) | (fin & fin_fail); // R11
  assign irq_d  = (irq_q & ~clr) | (fin & mode_q[MODE_IRQ_BIT]); // R9 R13

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boot_s1_q <= 1'b1;
      boot_s2_q <= 1'b1;
    end else begin
      boot_s1_q <= boot_select_pin;
      boot_s2_q <= boot_s1_q;
    end
  end

  // The key image stands for nonvolatile cells, so only power-on or a mass erase clears it, not the system reset.
  always_ff @(posedge clock or negedge por_n) begin
    if (!por_n) begin
      key_q    <= KEY_ERASED;
      keyset_q <= 1'b0;
      saved_q  <= PROT_OPEN;
    end else begin
      key_q    <= key_d;
      keyset_q <= keyset_d;
      saved_q  <= saved_d;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= FCC_IDLE;
      op_q <= CMD_NULL;
      cmd_q <= CMD_BURST_READ;
      mode_q <= 8'h00;
      data_q <= 16'h0000;
      addr_q <= 16'h0000;
      imm_q <= PROT_OPEN;
      stage_q <= PROT_OPEN;
      act_q <= 32'h00000000;
      seq_q <= SEQ_NONE;
      start_q <= 2'h0;
      dl_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      irq_q <= 1'b0;
      fl_rd_q <= 1'b0;
      fl_prog_q <= 1'b0;
      fl_erase_q <= 1'b0;
      fl_mass_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      cmd_q <= cmd_d;
      mode_q <= mode_d;
      data_q <= data_d;
      addr_q <= addr_d;
      imm_q <= imm_d;
      stage_q <= stage_d;
      act_q <= act_d;
      seq_q <= seq_d;
      start_q <= start_d;
      dl_q <= dl_d;
      done_q <= done_d;
      fail_q <= fail_d;
      irq_q <= irq_d;
      fl_rd_q <= fl_rd_d;
      fl_prog_q <= fl_prog_d;
      fl_erase_q <= fl_erase_d;
      fl_mass_q <= fl_mass_d;
    end
  end

  logic [15:0] prog_cnt_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prog_cnt_q <= 16'h0000;
    end else begin
      prog_cnt_q <= (state_q == FCC_PROG) ? prog_cnt_q + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_READ_DATA: assert property ( // R14
    state_q == FCC_READ && op_q == CMD_READ |=> data_q == $past(flash_rdata) && done_q
  ) else $error("Read data not loaded.");
  AST_PROG_TIME: assert property ( // R15
    state_q == FCC_PROG && tmr_done |-> prog_cnt_q == 16'(PROG_CYCLES - 1)
  ) else $error("Program time wrong.");
  AST_CMD_RETURN: assert property ( // R21
    state_q == FCC_PROG && tmr_done |=> cmd_q == CMD_BURST_READ && !busy && done_q
  ) else $error("Command register not restored.");
  AST_FAIL_CLEAR: assert property ( // R11
    clr && !fin |=> !fail_q && !done_q
  ) else $error("Status read did not clear flags.");
  AST_IRQ_GATE: assert property ( // R13
    fin && !mode_q[MODE_IRQ_BIT] && !irq_q |=> !flash_irq
  ) else $error("Interrupt raised while disabled.");
  AST_IRQ_SET: assert property ( // R9
    fin && mode_q[MODE_IRQ_BIT] |=> flash_irq && done_q
  ) else $error("Interrupt missing on completion.");
  AST_WP_FAIL: assert property ( // R26
    wr_stb && wr_addr == OFS_CMD && !busy && wr_data[7:0] == CMD_WRITE && !wr_ok
    |=> fail_q && !busy && !flash_prog_en
  ) else $error("Protected write not refused.");
  AST_BUSY_IGNORE: assert property ( // R25
    wr_stb && wr_addr == OFS_CMD && state_q == FCC_PROG && !tmr_done |=> $stable(cmd_q)
  ) else $error("Command taken while busy.");
  AST_MASS_KEY: assert property ( // R6
    state_q == FCC_MASS && tmr_done |=> key_q == KEY_ERASED && !keyset_q
  ) else $error("Mass erase kept the key.");
  AST_IMM: assert property ( // R5
    wr_stb && wr_addr == OFS_IMM |=> imm_q == $past(wr_data)
  ) else $error("Immediate protection not written.");
  AST_FW_HIDE: assert property ( // R1
    wr_stb && wr_addr == OFS_CMD && !busy && wr_data[7:0] == CMD_READ && !user
    |=> fail_q && !flash_rd_en
  ) else $error("Firmware area readable.");

  COV_PROG: cover property (state_q == FCC_PROG && tmr_done);
  COV_VERIFY_FAIL: cover property (state_q == FCC_READ && op_q == CMD_VERIFY && fin_fail);
  COV_PROTECT: cover property (fin && op_q == CMD_PROTECT && !fin_fail);
  COV_SET_CLR: cover property (fin && clr);

endmodule

//--- rtl/fcc_pkg.sv
package fcc_pkg;

  localparam int CLK_MHZ     = 40;
  localparam int T_PROG_NS   = 20000;
  localparam int T_EW_US     = 20000;
  localparam int T_MASS_US   = 2480000;
  localparam int PROG_CYCLES = (T_PROG_NS * CLK_MHZ + 999) / 1000;
  localparam int EW_CYCLES   = T_EW_US * CLK_MHZ;
  localparam int MASS_CYCLES = T_MASS_US * CLK_MHZ;
  localparam int TMR_W       = 27;

  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MODE   = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_DATA   = 8'h0C;
  localparam logic [7:0] OFS_ADDR   = 8'h10;
  localparam logic [7:0] OFS_SIGN   = 8'h14;
  localparam logic [7:0] OFS_KEYED  = 8'h18;
  localparam logic [7:0] OFS_IMM    = 8'h1C;
  localparam logic [7:0] OFS_INFO   = 8'h20;

  localparam logic [7:0] CMD_NULL        = 8'h00;
  localparam logic [7:0] CMD_READ        = 8'h01;
  localparam logic [7:0] CMD_WRITE       = 8'h02;
  localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
  localparam logic [7:0] CMD_VERIFY      = 8'h04;
  localparam logic [7:0] CMD_PAGE_ERASE  = 8'h05;
  localparam logic [7:0] CMD_MASS        = 8'h06;
  localparam logic [7:0] CMD_BURST_READ  = 8'h07;
  localparam logic [7:0] CMD_BURST_RW    = 8'h08;
  localparam logic [7:0] CMD_BURST_ERW   = 8'h09;
  localparam logic [7:0] CMD_PROTECT     = 8'h0C;

  localparam int ST_DONE_BIT  = 0;
  localparam int ST_FAIL_BIT  = 1;
  localparam int ST_BUSY_BIT  = 2;
  localparam int ST_IRQ_BIT   = 3;
  localparam int ST_BURST_BIT = 5;
  localparam int MODE_IRQ_BIT = 4;
  localparam int MODE_KEY_MSB = 7;
  localparam int MODE_KEY_LSB = 4;
  localparam int GRP_MSB      = 15;
  localparam int GRP_LSB      = 11;
  localparam int READ_PROT_BIT = 31;

  localparam logic [3:0]  KEY_ENABLE  = 4'hF;
  localparam logic [15:0] USER_TOP    = 16'hF800;
  localparam logic [15:0] MASS_ENABLE = 16'h0006;
  localparam logic [31:0] KEY_ERASED  = 32'h0000FFFF;
  localparam logic [31:0] PROT_OPEN   = 32'hFFFFFFFF;
  localparam logic [1:0]  START_CYCLES = 2'h3;
  localparam logic [1:0]  SEQ_NONE    = 2'h0;
  localparam logic [1:0]  SEQ_READ    = 2'h1;
  localparam logic [1:0]  SEQ_VERIFY  = 2'h2;

  typedef enum logic [4:0] {
    FCC_IDLE  = 5'b00001,
    FCC_READ  = 5'b00010,
    FCC_ERASE = 5'b00100,
    FCC_PROG  = 5'b01000,
    FCC_MASS  = 5'b10000
  } fcc_state_e;

endpackage

//--- rtl/fcc_timer.sv
`timescale 1ns/1ps
module fcc_timer #(
  parameter int W = 27
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  // The pulse comes on the last counted cycle, so a load of N spans N cycles.
  assign done = (count_q == W'(1));

  always_comb begin
    count_d = count_q;
    if (load) begin
      count_d = load_val;
    end else if (count_q != '0) begin
      count_d = count_q - W'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

//--- test/fcc_flash_model.sv
`timescale 1ns/1ps
module fcc_flash_model (
  input  wire logic        clock,
  input  wire logic        rd_en,
  input  wire logic        prog_en,
  input  wire logic        page_en,
  input  wire logic        mass_en,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata
);
  logic [15:0] mem [0:32767];
  // Outside a read strobe the array shows the inverse, so a late sample is caught.
  assign rdata = rd_en ? mem[addr[15:1]] : ~mem[addr[15:1]];
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'hFFFF;
  end
  // Programming can only clear bits, as in a real cell.
  always @(posedge clock) begin
    if (prog_en) mem[addr[15:1]] <= mem[addr[15:1]] & wdata;
    if (page_en) for (int j = 0; j < 256; j++) mem[{addr[15:9], j[7:0]}] <= 16'hFFFF;
    if (mass_en) for (int j = 0; j < 31744; j++) mem[j] <= 16'hFFFF;
  end
endmodule

//--- test/flash_command_controller_bench.sv
`timescale 1ns/1ps
module flash_command_controller_bench;
  import fcc_pkg::*;
  localparam int EW = 1000;
  logic        clock = 0;
  logic        arst_n = 0;
  logic        por_n = 0;
  logic        boot_select_pin = 1;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, st, a, d, seed;
  logic        hreadyout, hresp, download_mode, jtag_read_allow, flash_irq;
  logic        flash_rd_en, flash_prog_en, flash_page_erase_en, flash_mass_erase_en;
  logic [15:0] flash_addr, flash_wdata, flash_rdata;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          t0, el;
  always #12.5 clock = ~clock;
  fcc_flash_ctrl #(.EW_CYCLES_P(EW), .MASS_CYCLES_P(200)) DUT (
    .clock, .arst_n, .por_n, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata,
    .boot_select_pin, .download_mode, .jtag_read_allow, .flash_irq,
    .flash_rd_en, .flash_prog_en, .flash_page_erase_en, .flash_mass_erase_en,
    .flash_addr, .flash_wdata, .flash_rdata);
  fcc_flash_model M (.clock, .rd_en(flash_rd_en), .prog_en(flash_prog_en),
    .page_en(flash_page_erase_en), .mass_en(flash_mass_erase_en),
    .addr(flash_addr), .wdata(flash_wdata), .rdata(flash_rdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] exp);
    bus(0, ad, 32'h0);
    chk(rd, exp);
  endtask
  task automatic issue(input logic [7:0] c);
    t0 = cyc;
    bus(1, OFS_CMD, {24'h0, c});
  endtask
  task automatic waitdone();
    do bus(0, OFS_STATUS, 32'h0); while (rd[0] !== 1'b1);
    st = rd;
    el = cyc - t0;
  endtask
  task automatic run(input logic [7:0] c);
    issue(c);
    waitdone();
  endtask
  task automatic setad(input logic [31:0] ad, input logic [31:0] dd);
    bus(1, OFS_ADDR, ad);
    bus(1, OFS_DATA, dd);
  endtask
  // The key is the read address 0x0800 in the upper half and dd in the lower.
  task automatic key(input logic [31:0] dd);
    setad(32'h0800, 32'h0);
    run(CMD_READ);
    run(CMD_VERIFY);
    bus(1, OFS_DATA, dd);
    run(CMD_PROTECT);
  endtask
  // Only the system reset is pulsed, so the stored key image survives it.
  task automatic rst(input logic bp);
    boot_select_pin <= bp;
    arst_n <= 0;
    repeat (2) @(posedge clock);
    arst_n <= 1;
    repeat (4) @(posedge clock);
  endtask
  // A hang anywhere is cut short here and reported as a mismatch.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    seed = 32'h0000001C;
    repeat (4) @(posedge clock);
    M.mem[16'h7C10] = 16'h1234;
    arst_n <= 1;
    por_n <= 1;
    repeat (4) @(posedge clock);
    rc(OFS_CMD, 32'h7);
    rc(OFS_KEYED, PROT_OPEN);
    rc(OFS_IMM, PROT_OPEN);
    rc(8'h40, 32'h0);
    bus(1, OFS_STATUS, 32'hFF);
    rc(OFS_STATUS, 32'h20);
    chk(hresp, 1'b0);
    chk(jtag_read_allow, 1'b1);
    for (int i = 0; i < 5; i++) begin
      a = (rnd() % 32'h7C00) * 2;
      d = rnd() & 32'hFFFF;
      setad(a, d);
      run(CMD_ERASE_WRITE);
      chk(st[1:0], 2'b01);
      chk(el >= EW && el <= EW + 10, 1'b1);
      rc(OFS_STATUS, 32'h20);
      chk(M.mem[a[15:1]], d);
      bus(1, OFS_DATA, ~d & 32'hFFFF);
      run(CMD_READ);
      rc(OFS_DATA, d);
      bus(1, OFS_DATA, ~d & 32'hFFFF);
      run(CMD_VERIFY);
      chk(st[1], 1'b1);
    end
    setad(32'h0200, 32'h0);
    run(CMD_PAGE_ERASE);
    chk(M.mem[16'h0100], 16'hFFFF);
    bus(1, OFS_DATA, 32'hA5C3);
    issue(CMD_WRITE);
    bus(1, OFS_CMD, {24'h0, CMD_PAGE_ERASE});
    bus(0, OFS_STATUS, 32'h0);
    chk(rd[2], 1'b1);
    waitdone();
    chk(el >= 801 && el <= 810, 1'b1);
    chk(M.mem[16'h0100], 16'hA5C3);
    rc(OFS_CMD, 32'h7);
    bus(1, OFS_MODE, 32'h10);
    issue(CMD_READ);
    repeat (3) @(posedge clock);
    chk(flash_irq, 1'b1);
    rc(OFS_STATUS, 32'h29);
    chk(flash_irq, 1'b0);
    bus(1, OFS_MODE, 32'h0);
    run(CMD_READ);
    chk(st[3], 1'b0);
    bus(1, OFS_IMM, 32'hFFFFFFFD);
    setad(32'h0900, 32'h0);
    run(CMD_WRITE);
    chk(st[1:0], 2'b11);
    chk(M.mem[16'h0480], 16'hFFFF);
    bus(1, OFS_IMM, 32'h7FFFFFFF);
    @(posedge clock);
    chk(jtag_read_allow, 1'b0);
    run(CMD_WRITE);
    chk(st[1:0], 2'b01);
    bus(1, OFS_IMM, PROT_OPEN);
    @(posedge clock);
    chk(jtag_read_allow, 1'b1);
    setad(32'hF800, 32'h0);
    run(CMD_WRITE);
    chk(st[1:0], 2'b11);
    bus(1, OFS_KEYED, 32'hFFFFFFFD);
    bus(1, OFS_MODE, 32'hF0);
    key(32'hAA55);
    chk(st[1:0], 2'b01);
    key(32'h55AA);
    chk(st[1:0], 2'b11);
    key(32'hAA55);
    chk(st[1:0], 2'b01);
    setad(32'h0900, 32'h0);
    run(CMD_WRITE);
    chk(st[1:0], 2'b01);
    rst(1'b1);
    setad(32'h0900, 32'h0);
    run(CMD_WRITE);
    chk(st[1:0], 2'b11);
    rc(OFS_INFO, 32'h2);
    chk(download_mode, 1'b0);
    rst(1'b0);
    chk(download_mode, 1'b1);
    setad(32'h0900, 32'h0);
    run(CMD_WRITE);
    chk(st[1:0], 2'b01);
    setad(32'h0800, 32'h0);
    run(CMD_MASS);
    chk(st[1], 1'b1);
    run(CMD_READ);
    run(CMD_VERIFY);
    bus(1, OFS_DATA, 32'h6);
    run(CMD_MASS);
    chk(st[1:0], 2'b01);
    chk(M.mem[16'h0100], 16'hFFFF);
    chk(M.mem[16'h7C10], 16'h1234);
    rc(OFS_INFO, 32'h1);
    summarize();
  end
endmodule
